// ---- tb/flash_iap_write_guard_bench.sv ----
// bench: flash write guard against a behavioural key, region and status model
`default_nettype none
module flash_iap_write_guard_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = 20;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic flash_wr_req = 1'b0;
	logic flash_er_req = 1'b0;
	logic [14:0] flash_addr = 15'h0000;
	logic flash_done = 1'b0;
	logic flash_wr_go;
	logic flash_er_go;
	logic [14:0] flash_go_addr;
	logic data_nv_write_unlock;
	logic irq;
	int miscompares = 0;
	int n_checks = 0;
	int seed = 93644;
	int mkey = 0;
	int mstat = 0;
	int men = 0;
	bit mto = 1'b0;
	bit mbusy = 1'b0;
	logic [7:0] keys [4] = '{8'h4A, 8'h4C, 8'hBA, 8'hBC};
	logic [14:0] base;
	logic [14:0] off;

	fiw_guard #(.LIMIT_CYC(LIM)) u_dut (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.flash_wr_req(flash_wr_req), .flash_er_req(flash_er_req), .flash_addr(flash_addr),
		.flash_done(flash_done), .flash_wr_go(flash_wr_go), .flash_er_go(flash_er_go),
		.flash_go_addr(flash_go_addr), .data_nv_write_unlock(data_nv_write_unlock), .irq(irq)
	);

	always #50 clock = ~clock;

	// ************************************************
	// model and bus tasks
	// ************************************************
	function automatic bit ok(bit er, logic [14:0] a);
		logic [14:0] b;
		b = (mkey == 8'h4A || mkey == 8'hBA) ? 15'h7A00 : 15'h7C00;
		ok = (mkey != 0) && !mbusy && (er == (mkey >= 8'hBA)) && (a[14:9] == b[14:9]);
	endfunction

	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(negedge clock);
		if (a == 8'hC9) begin
			mkey = (d == 8'h4A || d == 8'h4C || d == 8'hBA || d == 8'hBC) ? d : 0;
		end
		if (a == 8'hE1) begin
			men = d & 7;
		end
		if (a == 8'hE2) begin
			mstat = mstat & ~d;
		end
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk("reg_rdata", {8'h00, reg_rdata & m}, {8'h00, e});
	endtask

	task automatic rd_unlock;
		rd(8'hC9, 8'hC0, {mkey != 0, mto, 6'h00});
	endtask

	task automatic req(bit er, logic [14:0] a);
		bit acc;
		acc = ok(er, a);
		@(posedge clock);
		flash_wr_req <= !er;
		flash_er_req <= er;
		flash_addr <= a;
		@(posedge clock);
		flash_wr_req <= 1'b0;
		flash_er_req <= 1'b0;
		@(negedge clock);
		chk("flash_wr_go", flash_wr_go, acc && !er);
		chk("flash_er_go", flash_er_go, acc && er);
		if (acc) begin
			chk("flash_go_addr", {1'b0, flash_go_addr}, {1'b0, a});
			mbusy = 1'b1;
		end else begin
			mstat = mstat | 4;
		end
		if (acc && !er) begin
			mkey = 0;
		end
		chk("irq", irq, (mstat & men) != 0);
	endtask

	task automatic pulse_done;
		@(posedge clock);
		flash_done <= 1'b1;
		@(posedge clock);
		flash_done <= 1'b0;
		mbusy = 1'b0;
		mstat = mstat | 2;
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ************************************************
	// tests
	// ************************************************
	initial begin
		#(100 * 3000);
		miscompares++;
		finish_test;
	end

	initial begin
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rd_unlock;
		rd(8'hE0, 8'hFF, 8'h00);
		rd(8'h10, 8'hFF, 8'h00);
		chk("irq", irq, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			base = i[0] ? 15'h7C00 : 15'h7A00;
			wr(8'hC9, keys[i]);
			rd_unlock;
			req(i >= 2, base + 15'h0200);
			off = 15'($random(seed)) & 15'h01FF;
			req(i >= 2, base | off);
			pulse_done;
			rd_unlock;
			req(i >= 2, base | 15'h01FF);
			if (mbusy) begin
				pulse_done;
			end
		end
		$display("test keys done");
		wr(8'hC9, 8'hBA);
		wr(8'hC9, {7'($random(seed)), 1'b1});
		rd_unlock;
		req(1'b1, 15'h7A10);
		req(1'b0, 15'h7C10);
		$display("test lock done");
		wr(8'hE1, 8'h04);
		chk("irq", irq, 1'b1);
		wr(8'hE1, 8'h00);
		chk("irq", irq, 1'b0);
		wr(8'hE2, 8'h07);
		wr(8'hE1, 8'h07);
		rd(8'hE1, 8'h07, 8'h07);
		rd(8'hE0, 8'h07, 8'h00);
		req(1'b0, 15'h7A00);
		rd(8'hE0, 8'h07, 8'h04);
		wr(8'hE2, 8'h04);
		chk("irq", irq, 1'b0);
		$display("test irq done");
		wr(8'hE1, 8'h01);
		wr(8'hE3, 8'h01);
		chk("data_nv_write_unlock", data_nv_write_unlock, 1'b1);
		wr(8'hC9, 8'hBC);
		req(1'b1, 15'h7C00);
		req(1'b1, 15'h7C20);
		repeat (LIM + 10) @(posedge clock);
		mto = 1'b1;
		mstat = mstat | 1;
		rd_unlock;
		chk("irq", irq, 1'b1);
		wr(8'hC9, 8'h00);
		rd_unlock;
		pulse_done;
		wr(8'hE3, 8'h00);
		mto = 1'b0;
		rd_unlock;
		chk("data_nv_write_unlock", data_nv_write_unlock, 1'b0);
		wr(8'hE2, 8'h07);
		chk("irq", irq, 1'b0);
		$display("test timeout done");
		finish_test;
	end
endmodule
`default_nettype wire

// ---- verilog/fiw_guard.sv ----
// flash write and erase guard: key register, region check, timeout flag, interrupts
`default_nettype none
// How it works
// - key 4Ah allows one byte write into 7A00 to 7BFF
// - key 4Ch allows one byte write into 7C00 to 7DFF
// - key BAh allows erasing the 512-byte region 7A00 to 7BFF
// - key BCh allows erasing the 512-byte region 7C00 to 7DFF
// - any other written value locks all writing and erasing
// - bit 7 reads one while writing or erasing is enabled, resets zero
// - bit 6 sets when a programming operation overruns its limit
// - bit 6 clears when flash and data-memory unlock are both disabled
module fiw_guard #(
	parameter int LIMIT_CYC = fiw_pkg::PROG_LIMIT_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic flash_wr_req,
	input wire logic flash_er_req,
	input wire logic [14:0] flash_addr,
	input wire logic flash_done,
	output logic flash_wr_go,
	output logic flash_er_go,
	output logic [14:0] flash_go_addr,
	output logic data_nv_write_unlock,
	output logic irq
);
	fiw_pkg::fiw_state_e state_q;
	logic er_hi_q;
	logic program_timeout_flag_q;
	logic busy_q;
	logic data_nv_q;
	logic [2:0] irq_status_q;
	logic [2:0] irq_enable_q;
	logic [7:0] rdata_q;
	logic wr_go_q;
	logic er_go_q;
	logic [14:0] go_addr_q;
	logic wr_unlock;
	logic wr_clear;
	logic wr_eectl;
	logic accept_wr;
	logic accept_er;
	logic reject;
	logic enabled;
	logic [2:0] irq_set;
	fiw_prog_if prog();

	localparam int REGION_ADDR_MSB_P = fiw_pkg::REGION_ADDR_MSB;
	function automatic logic in_region(input logic [14:0] a, input logic [14:0] base);
		in_region = a[14:REGION_ADDR_MSB_P + 1] == base[14:REGION_ADDR_MSB_P + 1];
	endfunction

	assign wr_unlock = reg_wr && reg_addr == fiw_pkg::ADDR_UNLOCK;
	assign wr_clear = reg_wr && reg_addr == fiw_pkg::ADDR_IRQ_CLEAR;
	assign wr_eectl = reg_wr && reg_addr == fiw_pkg::ADDR_EE_CTRL;
	assign enabled = state_q != fiw_pkg::FIW_LOCKED;

	// ************************************************
	// request qualification
	// ************************************************
	always_comb begin
		accept_wr = 1'b0;
		accept_er = 1'b0;
		case (state_q)
			fiw_pkg::FIW_WR_LO: accept_wr = flash_wr_req
				&& in_region(flash_addr, fiw_pkg::REGION_LO_BASE);
			fiw_pkg::FIW_WR_HI: accept_wr = flash_wr_req
				&& in_region(flash_addr, fiw_pkg::REGION_HI_BASE);
			fiw_pkg::FIW_ER: accept_er = flash_er_req && in_region(flash_addr,
				er_hi_q ? fiw_pkg::REGION_HI_BASE : fiw_pkg::REGION_LO_BASE);
			default: begin
			end
		endcase
		if (busy_q) begin
			accept_wr = 1'b0;
			accept_er = 1'b0;
		end
	end
	assign reject = (flash_wr_req && !accept_wr) || (flash_er_req && !accept_er);

	// ************************************************
	// key state
	// ************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= fiw_pkg::FIW_LOCKED;
			er_hi_q <= 1'b0;
		end else if (wr_unlock) begin
			case (reg_wdata)
				fiw_pkg::KEY_WR_LO: state_q <= fiw_pkg::FIW_WR_LO;
				fiw_pkg::KEY_WR_HI: state_q <= fiw_pkg::FIW_WR_HI;
				fiw_pkg::KEY_ER_LO: begin
					state_q <= fiw_pkg::FIW_ER;
					er_hi_q <= 1'b0;
				end
				fiw_pkg::KEY_ER_HI: begin
					state_q <= fiw_pkg::FIW_ER;
					er_hi_q <= 1'b1;
				end
				default: state_q <= fiw_pkg::FIW_LOCKED;
			endcase
		end else if (accept_wr) begin
			state_q <= fiw_pkg::FIW_LOCKED;
		end
	end

	// ************************************************
	// operation launch and busy
	// ************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_go_q <= 1'b0;
			er_go_q <= 1'b0;
			go_addr_q <= 15'h0000;
			busy_q <= 1'b0;
		end else begin
			wr_go_q <= accept_wr;
			er_go_q <= accept_er;
			if (accept_wr || accept_er) begin
				go_addr_q <= flash_addr;
				busy_q <= 1'b1;
			end else if (flash_done) begin
				busy_q <= 1'b0;
			end
		end
	end
	assign prog.busy = busy_q;
	assign prog.start = accept_wr || accept_er;

	fiw_watchdog #(.LIMIT_CYC(LIMIT_CYC)) u_dog (
		.clock(clock),
		.rst_b(rst_b),
		.prog(prog)
	);

	// ************************************************
	// data-memory unlock and timeout flag
	// ************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			data_nv_q <= 1'b0;
		end else if (wr_eectl) begin
			data_nv_q <= reg_wdata[0];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			program_timeout_flag_q <= 1'b0;
		end else if (prog.expired) begin
			program_timeout_flag_q <= 1'b1;
		end else if (!enabled && !data_nv_q) begin
			program_timeout_flag_q <= 1'b0;
		end
	end

	// ************************************************
	// interrupts
	// ************************************************
	assign irq_set = {reject, flash_done && busy_q, prog.expired};
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			irq_status_q <= fiw_pkg::RST_IRQ;
			irq_enable_q <= fiw_pkg::RST_IRQ;
		end else begin
			irq_status_q <= (irq_status_q & ~(wr_clear ? reg_wdata[2:0] : 3'h0)) | irq_set;
			if (reg_wr && reg_addr == fiw_pkg::ADDR_IRQ_ENABLE) begin
				irq_enable_q <= reg_wdata[2:0];
			end
		end
	end
	assign irq = |(irq_status_q & irq_enable_q);

	// ************************************************
	// read port
	// ************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= fiw_pkg::RST_UNLOCK;
		end else if (reg_rd) begin
			if (reg_addr == fiw_pkg::ADDR_UNLOCK) begin
				rdata_q <= {enabled, program_timeout_flag_q, 6'h00};
			end else if (reg_addr == fiw_pkg::ADDR_IRQ_STATUS) begin
				rdata_q <= {5'h00, irq_status_q};
			end else if (reg_addr == fiw_pkg::ADDR_IRQ_ENABLE) begin
				rdata_q <= {5'h00, irq_enable_q};
			end else if (reg_addr == fiw_pkg::ADDR_EE_CTRL) begin
				rdata_q <= {7'h00, data_nv_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign flash_wr_go = wr_go_q;
	assign flash_er_go = er_go_q;
	assign flash_go_addr = go_addr_q;
	assign data_nv_write_unlock = data_nv_q;

	// ************************************************
	// checks
	// ************************************************
	property p_key_wr_lo;
		@(posedge clock) disable iff (!rst_b)
		wr_unlock && reg_wdata == fiw_pkg::KEY_WR_LO |=> state_q == fiw_pkg::FIW_WR_LO;
	endproperty
	a_key_wr_lo: assert property (p_key_wr_lo) else $error("4A key not taken");

	property p_key_wr_hi;
		@(posedge clock) disable iff (!rst_b)
		wr_unlock && reg_wdata == fiw_pkg::KEY_WR_HI |=> state_q == fiw_pkg::FIW_WR_HI;
	endproperty
	a_key_wr_hi: assert property (p_key_wr_hi) else $error("4C key not taken");

	property p_key_er_lo;
		@(posedge clock) disable iff (!rst_b)
		wr_unlock && reg_wdata == fiw_pkg::KEY_ER_LO |=> state_q == fiw_pkg::FIW_ER && !er_hi_q;
	endproperty
	a_key_er_lo: assert property (p_key_er_lo) else $error("BA key not taken");

	property p_key_er_hi;
		@(posedge clock) disable iff (!rst_b)
		wr_unlock && reg_wdata == fiw_pkg::KEY_ER_HI |=> state_q == fiw_pkg::FIW_ER && er_hi_q;
	endproperty
	a_key_er_hi: assert property (p_key_er_hi) else $error("BC key not taken");

	property p_other_locks;
		@(posedge clock) disable iff (!rst_b)
		wr_unlock && reg_wdata != fiw_pkg::KEY_WR_LO && reg_wdata != fiw_pkg::KEY_WR_HI
			&& reg_wdata != fiw_pkg::KEY_ER_LO && reg_wdata != fiw_pkg::KEY_ER_HI
			|=> !enabled;
	endproperty
	a_other_locks: assert property (p_other_locks) else $error("other value did not lock");

	property p_read_flag;
		@(posedge clock) disable iff (!rst_b)
		reg_rd && reg_addr == fiw_pkg::ADDR_UNLOCK |=> reg_rdata[7] == $past(enabled);
	endproperty
	a_read_flag: assert property (p_read_flag) else $error("enable flag misread");

	property p_timeout_set;
		@(posedge clock) disable iff (!rst_b)
		prog.expired |=> program_timeout_flag_q;
	endproperty
	a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");

	property p_timeout_clr;
		@(posedge clock) disable iff (!rst_b)
		!prog.expired && !enabled && !data_nv_q |=> !program_timeout_flag_q;
	endproperty
	a_timeout_clr: assert property (p_timeout_clr) else $error("timeout flag not cleared");

	property p_locked_ignores;
		@(posedge clock) disable iff (!rst_b)
		!enabled && (flash_wr_req || flash_er_req) |=> !flash_wr_go && !flash_er_go;
	endproperty
	a_locked_ignores: assert property (p_locked_ignores) else $error("locked request launched");

	property p_single_write;
		@(posedge clock) disable iff (!rst_b)
		accept_wr && !wr_unlock |=> !enabled;
	endproperty
	a_single_write: assert property (p_single_write) else $error("write did not relock");

	property p_busy_blocks;
		@(posedge clock) disable iff (!rst_b)
		busy_q && (flash_wr_req || flash_er_req) |=> !flash_wr_go && !flash_er_go;
	endproperty
	a_busy_blocks: assert property (p_busy_blocks) else $error("busy request launched");

	property p_wr_lo_out;
		@(posedge clock) disable iff (!rst_b)
		state_q == fiw_pkg::FIW_WR_LO && !in_region(flash_addr, fiw_pkg::REGION_LO_BASE)
			|=> !flash_wr_go && !flash_er_go;
	endproperty
	a_wr_lo_out: assert property (p_wr_lo_out) else $error("low write off region");

	property p_wr_hi_out;
		@(posedge clock) disable iff (!rst_b)
		state_q == fiw_pkg::FIW_WR_HI && !in_region(flash_addr, fiw_pkg::REGION_HI_BASE)
			|=> !flash_wr_go && !flash_er_go;
	endproperty
	a_wr_hi_out: assert property (p_wr_hi_out) else $error("high write off region");

	property p_erase_stays;
		@(posedge clock) disable iff (!rst_b)
		state_q == fiw_pkg::FIW_ER && !wr_unlock |=> state_q == fiw_pkg::FIW_ER;
	endproperty
	a_erase_stays: assert property (p_erase_stays) else $error("erase key dropped");

	property p_er_hi_out;
		@(posedge clock) disable iff (!rst_b)
		state_q == fiw_pkg::FIW_ER && er_hi_q && !in_region(flash_addr, fiw_pkg::REGION_HI_BASE)
			|=> !flash_wr_go && !flash_er_go;
	endproperty
	a_er_hi_out: assert property (p_er_hi_out) else $error("high erase off region");

	property p_flag_read;
		@(posedge clock) disable iff (!rst_b)
		reg_rd && reg_addr == fiw_pkg::ADDR_UNLOCK |=> reg_rdata[6] == $past(program_timeout_flag_q);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("timeout flag misread");
endmodule
`default_nettype wire

// ---- verilog/fiw_pkg.sv ----
// package: offsets, keys, fields, reset values and timing for the flash write guard
`default_nettype none
package fiw_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0] ADDR_UNLOCK = 8'hC9;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE0;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE1;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hE2;
	localparam logic [7:0] ADDR_EE_CTRL = 8'hE3;
	// ************************************************
	// keys
	// ************************************************
	localparam logic [7:0] KEY_WR_LO = 8'h4A;
	localparam logic [7:0] KEY_WR_HI = 8'h4C;
	localparam logic [7:0] KEY_ER_LO = 8'hBA;
	localparam logic [7:0] KEY_ER_HI = 8'hBC;
	// ************************************************
	// fields and regions
	// ************************************************
	localparam int BIT_ENABLED = 7;
	localparam int BIT_TIMEOUT = 6;
	localparam int IRQ_BIT_TIMEOUT = 0;
	localparam int IRQ_BIT_DONE = 1;
	localparam int IRQ_BIT_REJECT = 2;
	localparam logic [14:0] REGION_LO_BASE = 15'h7A00;
	localparam logic [14:0] REGION_HI_BASE = 15'h7C00;
	localparam int REGION_ADDR_MSB = 8;
	localparam logic [7:0] RST_UNLOCK = 8'h00;
	localparam logic [2:0] RST_IRQ = 3'h0;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int PROG_LIMIT_US = 5000;
	localparam int PROG_LIMIT_CYC = PROG_LIMIT_US * (CLK_HZ / 1_000_000);
	typedef enum logic [3:0] {
		FIW_LOCKED = 4'b0001,
		FIW_WR_LO = 4'b0010,
		FIW_WR_HI = 4'b0100,
		FIW_ER = 4'b1000
	} fiw_state_e;
endpackage
`default_nettype wire

// ---- verilog/fiw_prog_if.sv ----
// interface: programming request path between guard and its watchdog
`default_nettype none
interface fiw_prog_if;
	logic busy;
	logic start;
	logic expired;
	modport guard (input expired, output busy, output start);
	modport dog (input busy, input start, output expired);
endinterface
`default_nettype wire

// ---- verilog/fiw_watchdog.sv ----
// programming time limit counter
`default_nettype none
module fiw_watchdog #(
	parameter int LIMIT_CYC = fiw_pkg::PROG_LIMIT_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	fiw_prog_if.dog prog
);
	logic [23:0] cnt_q;
	logic expired_q;

	assign prog.expired = expired_q;

	// ************************************************
	// count while an operation is busy
	// ************************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 24'h000000;
			expired_q <= 1'b0;
		end else if (prog.start || !prog.busy) begin
			cnt_q <= 24'h000000;
			expired_q <= 1'b0;
		end else if (cnt_q == 24'(LIMIT_CYC - 1)) begin
			expired_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
		end
	end
endmodule
`default_nettype wire
